// *** core/icf_consts.svh ***
// constants of the interrupt enable and flag block
// assumes registers sit at word index, byte address = index * 4
`ifndef ICF_CONSTS_SVH
`define ICF_CONSTS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define ICF_IDX_CTRL_LO     8'h0b
`define ICF_IDX_CTRL_HI     8'h8b
`define ICF_IDX_PER_EN      8'h8c
`define ICF_IDX_PER_FLAG    8'h0c
`define ICF_IDX_EVT_STAT    8'hc0
`define ICF_IDX_EVT_MASK    8'hc1

// ----------------------------------------
// interrupt_control fields
// ----------------------------------------
`define ICF_B_GLOBAL_EN     7
`define ICF_B_PER_GROUP_EN  6
`define ICF_B_T0_EN         5
`define ICF_B_EXT_EN        4
`define ICF_B_PCHG_EN       3
`define ICF_B_T0_FLAG       2
`define ICF_B_EXT_FLAG      1
`define ICF_B_PCHG_FLAG     0

// ----------------------------------------
// peripheral enable / flag fields
// ----------------------------------------
`define ICF_B_CONVERTER     6
`define ICF_B_CAPCOMP       2
`define ICF_B_PERIOD_MATCH  1
`define ICF_B_T1_OVERFLOW   0
`define ICF_PER_MASK        8'h47

// ----------------------------------------
// reset values and responses
// ----------------------------------------
`define ICF_RST_CTRL        7'h00
`define ICF_RST_PER         8'h00
`define ICF_RST_EVT         7'h00
`define ICF_RESP_OKAY       2'h0
`define ICF_RESP_SLVERR     2'h2

`endif

// *** core/icf_pkg.sv ***
// types of the interrupt enable and flag block
// assumes icf_consts.svh for the register constants; the enum encodings are set here
package icf_pkg;

    typedef enum logic [1:0] {
        ICF_CC_OFF     = 2'b00,
        ICF_CC_CAPTURE = 2'b01,
        ICF_CC_COMPARE = 2'b10,
        ICF_CC_PWM     = 2'b11
    } icf_ccmode_t;

    typedef enum logic [2:0] {
        ICF_SEL_NONE = 3'b000,
        ICF_SEL_CTRL = 3'b001,
        ICF_SEL_PEN  = 3'b010,
        ICF_SEL_PFL  = 3'b011,
        ICF_SEL_STAT = 3'b100,
        ICF_SEL_MASK = 3'b101
    } icf_sel_t;

endpackage

// *** core/icf_req_if.sv ***
// enables and flags handed to the request gate, request back
// assumes one clock domain, driven by icf_irq_flags
`timescale 1ns/1ns
interface icf_req_if;
    logic [7:0] ctrl;
    logic [7:0] pen;
    logic [7:0] pfl;
    logic       req;

    modport src  (output ctrl, output pen, output pfl, input req);
    modport gate (input ctrl, input pen, input pfl, output req);
endinterface

// *** core/icf_req_gate.sv ***
// combines flags and enables into the request to the core
// assumes flags and enables come from flip-flops
`timescale 1ns/1ns
module icf_req_gate
    import icf_pkg::*;
(
    // enables, flags, request
    icf_req_if.gate bus
);
`include "icf_consts.svh"

    logic core_term;
    logic per_term;

    // ----------------------------------------
    // request combine
    // ----------------------------------------
    always_comb begin
        core_term = (bus.ctrl[`ICF_B_T0_EN]
                     & bus.ctrl[`ICF_B_T0_FLAG])
                  | (bus.ctrl[`ICF_B_EXT_EN]
                     & bus.ctrl[`ICF_B_EXT_FLAG])
                  | (bus.ctrl[`ICF_B_PCHG_EN]
                     & bus.ctrl[`ICF_B_PCHG_FLAG]);
        per_term  = bus.ctrl[`ICF_B_PER_GROUP_EN]
                  & (|(bus.pen & bus.pfl & `ICF_PER_MASK));
    end

    assign bus.req = bus.ctrl[`ICF_B_GLOBAL_EN]
                   & (core_term | per_term);

endmodule

// *** core/icf_irq_flags.sv ***
// interrupt enable and flag logic with an axi4-lite register slave
// assumes event inputs are one-cycle pulses synchronous to aclk
`timescale 1ns/1ns

// Notes on behaviour
// - flags set regardless of any enable
// - control bit 7 gates every core request
// - control bit 6 gates peripheral requests
// - control bit 5 enables timer0 overflow
// - control bit 2 set on timer0 overflow
// - control bit 1 set on external pin
// - control bit 0 set on nibble change
// - control register reachable at two addresses
// - peripheral enable register, one bit each
// - peripheral flag register pairs with enables
// - capcomp flag by capture or compare mode
// - period match flag set, software clears
// - timer1 overflow flag set, software clears
module icf_irq_flags
    import icf_pkg::*;
#(
    parameter int AW = 12
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // axi4-lite write address
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]    s_axi_awprot,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    // axi4-lite write response
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    // axi4-lite read address
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic [2:0]    s_axi_arprot,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    // axi4-lite read data
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    // interrupt sources
    input  wire logic          timer0_overflow,
    input  wire logic          ext_pin_event,
    input  wire logic [3:0]    port_b_upper_nibble,
    input  wire logic          converter_done,
    input  wire logic          capture_event,
    input  wire logic          compare_event,
    input  wire icf_ccmode_t   capcomp_mode,
    input  wire logic          period_match,
    input  wire logic          t1_overflow,
    // requests
    output logic               core_irq_req,
    output logic               irq
);
`include "icf_consts.svh"

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic icf_sel_t decode(input logic [AW-1:0] a);
        logic [AW-3:0] idx;
        idx = a[AW-1:2];
        decode = ICF_SEL_NONE;
        if (a[1:0] == 2'h0) begin
            if (idx == (AW-2)'(`ICF_IDX_CTRL_LO)
                || idx == (AW-2)'(`ICF_IDX_CTRL_HI)) begin
                decode = ICF_SEL_CTRL;
            end else if (idx == (AW-2)'(`ICF_IDX_PER_EN)) begin
                decode = ICF_SEL_PEN;
            end else if (idx == (AW-2)'(`ICF_IDX_PER_FLAG)) begin
                decode = ICF_SEL_PFL;
            end else if (idx == (AW-2)'(`ICF_IDX_EVT_STAT)) begin
                decode = ICF_SEL_STAT;
            end else if (idx == (AW-2)'(`ICF_IDX_EVT_MASK)) begin
                decode = ICF_SEL_MASK;
            end
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [AW-1:0] awaddr_reg;
    logic [7:0]    wdata_reg, pen_reg, pfl_reg, pfl_next, ctrl_full;
    logic [1:0]    bresp_reg, rresp_reg;
    logic [31:0]   rdata_reg;
    logic [7:1]    ctrl_reg, ctrl_next;
    logic [3:0]    nibble_reg;
    logic [6:0]    evt_stat_reg, evt_mask_reg, src_events;
    logic          aw_full_reg, w_full_reg, wstrb0_reg, nibble_seen_reg;
    logic          bvalid_reg, rvalid_reg, wr_en;
    logic          pchg_flag_reg, pchg_flag_next, pchg_event, capcomp_event;
    icf_sel_t      wr_sel, rd_sel;

    icf_req_if req_bus ();

    // ----------------------------------------
    // write channels
    // ----------------------------------------
    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready  = !w_full_reg && !bvalid_reg;
    assign wr_en  = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_sel = decode(awaddr_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            awaddr_reg  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end else if (wr_en) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wdata_reg  <= 8'h00;
            wstrb0_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
        end else if (wr_en) begin
            w_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `ICF_RESP_OKAY;
        end else if (wr_en) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_sel == ICF_SEL_NONE) ?
                          `ICF_RESP_SLVERR : `ICF_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // ----------------------------------------
    // source events
    // ----------------------------------------
    assign pchg_event = nibble_seen_reg
                     && (port_b_upper_nibble != nibble_reg);
    assign capcomp_event = (capcomp_mode == ICF_CC_CAPTURE && capture_event)
        || (capcomp_mode == ICF_CC_COMPARE && compare_event);
    assign src_events = {converter_done, capcomp_event, period_match,
                         t1_overflow, timer0_overflow, ext_pin_event,
                         pchg_event};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nibble_reg      <= 4'h0;
            nibble_seen_reg <= 1'b0;
        end else begin
            nibble_reg      <= port_b_upper_nibble;
            nibble_seen_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // interrupt_control
    // ----------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_en && wstrb0_reg && wr_sel == ICF_SEL_CTRL) begin
            ctrl_next = wdata_reg[7:1];
        end
        ctrl_next[`ICF_B_T0_FLAG]  |= timer0_overflow;
        ctrl_next[`ICF_B_EXT_FLAG] |= ext_pin_event;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `ICF_RST_CTRL;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // port change flag keeps its value through reset
    always_comb begin
        pchg_flag_next = pchg_flag_reg;
        if (wr_en && wstrb0_reg && wr_sel == ICF_SEL_CTRL) begin
            pchg_flag_next = wdata_reg[`ICF_B_PCHG_FLAG];
        end
        pchg_flag_next = pchg_flag_next | pchg_event;
    end

    always_ff @(posedge aclk) begin
        pchg_flag_reg <= pchg_flag_next;
    end

    assign ctrl_full = {ctrl_reg, pchg_flag_reg};

    // ----------------------------------------
    // peripheral enable and flags
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pen_reg <= `ICF_RST_PER;
        end else if (wr_en && wstrb0_reg && wr_sel == ICF_SEL_PEN) begin
            pen_reg <= wdata_reg & `ICF_PER_MASK;
        end
    end

    always_comb begin
        pfl_next = pfl_reg;
        if (wr_en && wstrb0_reg && wr_sel == ICF_SEL_PFL) begin
            pfl_next = wdata_reg & `ICF_PER_MASK;
        end
        pfl_next[`ICF_B_CONVERTER]    |= converter_done;
        pfl_next[`ICF_B_CAPCOMP]      |= capcomp_event;
        pfl_next[`ICF_B_PERIOD_MATCH] |= period_match;
        pfl_next[`ICF_B_T1_OVERFLOW]  |= t1_overflow;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pfl_reg <= `ICF_RST_PER;
        end else begin
            pfl_reg <= pfl_next;
        end
    end

    // ----------------------------------------
    // event status, mask, irq
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_stat_reg <= `ICF_RST_EVT;
        end else if (wr_en && wstrb0_reg && wr_sel == ICF_SEL_STAT) begin
            evt_stat_reg <= (evt_stat_reg & ~wdata_reg[6:0]) | src_events;
        end else begin
            evt_stat_reg <= evt_stat_reg | src_events;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_mask_reg <= `ICF_RST_EVT;
        end else if (wr_en && wstrb0_reg && wr_sel == ICF_SEL_MASK) begin
            evt_mask_reg <= wdata_reg[6:0];
        end
    end

    assign irq = |(evt_stat_reg & evt_mask_reg);

    // ----------------------------------------
    // request gate
    // ----------------------------------------
    assign req_bus.ctrl = ctrl_full;
    assign req_bus.pen  = pen_reg;
    assign req_bus.pfl  = pfl_reg;

    icf_req_gate u_gate (
        .bus (req_bus.gate)
    );

    assign core_irq_req = req_bus.req;

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    assign s_axi_arready = !rvalid_reg;
    assign rd_sel        = decode(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `ICF_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= `ICF_RESP_OKAY;
            case (rd_sel)
                ICF_SEL_CTRL: rdata_reg <= {24'h0, ctrl_full};
                ICF_SEL_PEN:  rdata_reg <= {24'h0, pen_reg};
                ICF_SEL_PFL:  rdata_reg <= {24'h0, pfl_reg};
                ICF_SEL_STAT: rdata_reg <= {25'h0, evt_stat_reg};
                ICF_SEL_MASK: rdata_reg <= {25'h0, evt_mask_reg};
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= `ICF_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_T0_SET: assert property (
        timer0_overflow |=> ctrl_reg[`ICF_B_T0_FLAG])
        else $error("timer0 flag not set");
    AST_EXT_SET: assert property (
        ext_pin_event |=> ctrl_reg[`ICF_B_EXT_FLAG])
        else $error("pin flag not set");
    AST_PCHG_SET: assert property (
        pchg_event |=> pchg_flag_reg)
        else $error("port change flag not set");
    AST_GLOBAL_OFF: assert property (
        !ctrl_reg[`ICF_B_GLOBAL_EN] |-> !core_irq_req)
        else $error("request with global enable off");
    AST_T0_REQ: assert property (
        ctrl_reg[`ICF_B_GLOBAL_EN] && ctrl_reg[`ICF_B_T0_EN]
        && ctrl_reg[`ICF_B_T0_FLAG] |-> core_irq_req)
        else $error("timer0 request missing");
    AST_PER_GROUP: assert property (
        ctrl_reg[`ICF_B_GLOBAL_EN] && (|(pen_reg & pfl_reg))
        |-> core_irq_req == (ctrl_reg[`ICF_B_PER_GROUP_EN]
            || (|(ctrl_full[5:3] & ctrl_full[2:0]))))
        else $error("peripheral gating wrong");
    AST_PWM_QUIET: assert property (
        capcomp_mode == ICF_CC_PWM && !pfl_reg[`ICF_B_CAPCOMP]
        && !(wr_en && wr_sel == ICF_SEL_PFL)
        |=> !pfl_reg[`ICF_B_CAPCOMP])
        else $error("capcomp flag set in pwm mode");
    AST_PER_SET: assert property (
        period_match && t1_overflow
        |=> pfl_reg[`ICF_B_PERIOD_MATCH] && pfl_reg[`ICF_B_T1_OVERFLOW])
        else $error("timer flags not set");
    AST_CTRL_WRITE: assert property (
        wr_en && wstrb0_reg && wr_sel == ICF_SEL_CTRL
        |=> ctrl_reg[7:3] == $past(wdata_reg[7:3]) ##1 !bvalid_reg
            || s_axi_bready == 1'b0)
        else $error("control write lost");
    AST_RESET_CLEAR: assert property (
        $past(!aresetn) |-> pen_reg == 8'h00 && ctrl_reg[7:3] == 5'h00)
        else $error("enables not cleared by reset");
    AST_BRESP: assert property (
        wr_en |=> s_axi_bvalid)
        else $error("no write response");

    COV_T0_REQ: cover property (timer0_overflow ##1 core_irq_req);
    COV_PER_REQ: cover property (
        ctrl_reg[`ICF_B_PER_GROUP_EN] && core_irq_req && pfl_reg != 8'h00);
    COV_HI_ALIAS: cover property (
        wr_en && awaddr_reg[AW-1:2] == (AW-2)'(`ICF_IDX_CTRL_HI));
    COV_SET_CLEAR: cover property (
        wr_en && wr_sel == ICF_SEL_CTRL && timer0_overflow);

endmodule

// *** testbench/icf_src_model.sv ***
// event source model: timers, pin and port nibble feeding the block
// assumes commands change right after a rising edge of aclk
`timescale 1ns/1ns
module icf_src_model (
    // clock and command
    input  wire logic       aclk,
    input  wire logic [7:0] fire,
    // pulses and port pins to the block
    output logic [6:0]      evt,
    output logic [3:0]      nib
);
    // ----------------------------------------
    // one-cycle pulses, nibble toggles
    // ----------------------------------------
    logic [6:0] evt_q = 7'h00;
    logic [3:0] nib_q = 4'h0;
    always @(posedge aclk) begin
        evt_q <= fire[6:0];
        if (fire[7]) begin
            nib_q <= nib_q ^ 4'h8;
        end
    end
    assign evt = evt_q;
    assign nib = nib_q;
endmodule

// *** testbench/test_core_interrupt_enable_flag_logic.sv ***
// self-checking bench of the interrupt enable and flag block
// assumes icf_consts.svh on the include path, one 100 MHz clock
`timescale 1ns/1ns
`include "icf_consts.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    fail_count++; $display("FAIL t=%0t got=%h exp=%h", $time, a, e); \
    end end
module test_core_interrupt_enable_flag_logic;
    import icf_pkg::*;
    // ----------------------------------------
    // addresses and responses
    // ----------------------------------------
    localparam logic [11:0] A_CLO = 12'(`ICF_IDX_CTRL_LO) << 2;
    localparam logic [11:0] A_CHI = 12'(`ICF_IDX_CTRL_HI) << 2;
    localparam logic [11:0] A_PEN = 12'(`ICF_IDX_PER_EN) << 2;
    localparam logic [11:0] A_PFL = 12'(`ICF_IDX_PER_FLAG) << 2;
    localparam logic [11:0] A_STA = 12'(`ICF_IDX_EVT_STAT) << 2;
    localparam logic [11:0] A_MSK = 12'(`ICF_IDX_EVT_MASK) << 2;
    localparam logic [1:0]  OK    = `ICF_RESP_OKAY;
    localparam logic [1:0]  ER    = `ICF_RESP_SLVERR;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [7:0]  fire = 8'h00;
    icf_ccmode_t mode = ICF_CC_OFF;
    logic        awready, wready, bvalid, arready, rvalid, req, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [6:0]  evt;
    logic [3:0]  nib;
    int          fail_count = 0;
    int          checks_done = 0;
    int          cyc = 0;

    always #5 aclk = ~aclk;

    icf_src_model src (.aclk(aclk), .fire(fire), .evt(evt), .nib(nib));

    icf_irq_flags dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .timer0_overflow(evt[0]), .ext_pin_event(evt[1]),
        .port_b_upper_nibble(nib), .converter_done(evt[2]),
        .capture_event(evt[3]), .compare_event(evt[4]),
        .capcomp_mode(mode), .period_match(evt[5]),
        .t1_overflow(evt[6]), .core_irq_req(req), .irq(irq)
    );

    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] er = OK);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        `CHK(bresp, er)
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e,
                      input logic [1:0] er = OK, input logic [7:0] m = 8'hff);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        `CHK(rdata & {24'h0, m}, {24'h0, e & m})
        `CHK(rresp, er)
    endtask

    task automatic fire_evt(input logic [7:0] v);
        fire <= v;
        @(posedge aclk);
        fire <= 8'h00;
        repeat (2) @(posedge aclk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(A_CLO, 8'h00, OK, 8'hfe);
        rd(A_PEN, 8'h00);
        rd(A_PFL, 8'h00);
        `CHK(req, 1'b0)
        $display("test reset done");
    endtask

    task automatic t_flags;
        wr(A_CLO, 8'h00);
        fire_evt(8'h83);
        rd(A_CLO, 8'h07);
        `CHK(req, 1'b0)
        wr(A_CHI, 8'h05);
        rd(A_CLO, 8'h05);
        rd(A_CHI, 8'h05);
        $display("test flags done");
    endtask

    task automatic t_gate;
        logic [7:0] en_t[3] = '{8'h20, 8'h10, 8'h08};
        logic [7:0] fl_t[3] = '{8'h04, 8'h02, 8'h01};
        logic [7:0] fv_t[3] = '{8'h01, 8'h02, 8'h80};
        for (int i = 0; i < 3; i++) begin
            wr(A_CLO, en_t[i]);
            fire_evt(fv_t[i]);
            `CHK(req, 1'b0)
            wr(A_CLO, 8'h80 | en_t[i] | fl_t[i]);
            `CHK(req, 1'b1)
            wr(A_CLO, 8'h80 | fl_t[i]);
            `CHK(req, 1'b0)
        end
        wr(A_CLO, 8'h00);
        $display("test gating done");
    endtask

    task automatic t_periph;
        wr(A_PEN, 8'hff);
        rd(A_PEN, 8'h47);
        wr(A_PFL, 8'h00);
        fire_evt(8'h18);
        rd(A_PFL, 8'h00);
        mode <= ICF_CC_PWM;
        fire_evt(8'h18);
        rd(A_PFL, 8'h00);
        mode <= ICF_CC_CAPTURE;
        fire_evt(8'h10);
        rd(A_PFL, 8'h00);
        fire_evt(8'h08);
        rd(A_PFL, 8'h04);
        wr(A_PFL, 8'h00);
        mode <= ICF_CC_COMPARE;
        fire_evt(8'h08);
        rd(A_PFL, 8'h00);
        fire_evt(8'h10);
        rd(A_PFL, 8'h04);
        fire_evt(8'h64);
        rd(A_PFL, 8'h47);
        wr(A_CLO, 8'h80);
        `CHK(req, 1'b0)
        wr(A_CLO, 8'hc0);
        `CHK(req, 1'b1)
        wr(A_PEN, 8'h00);
        `CHK(req, 1'b0)
        wr(A_PFL, 8'h00);
        rd(A_PFL, 8'h00);
        wr(A_CLO, 8'h00);
        $display("test peripheral done");
    endtask

    task automatic t_evt;
        wr(A_STA, 8'h7f);
        rd(A_STA, 8'h00);
        fire_evt(8'h01);
        rd(A_STA, 8'h04);
        `CHK(irq, 1'b0)
        wr(A_MSK, 8'h04);
        `CHK(irq, 1'b1)
        wr(A_STA, 8'h04);
        `CHK(irq, 1'b0)
        wr(12'h100, 8'h00, ER);
        rd(12'h100, 8'h00, ER);
        $display("test event status done");
    endtask

    // ----------------------------------------
    // closing, timeout, main sequence
    // ----------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_flags();
        t_gate();
        t_periph();
        t_evt();
        end_of_test();
    end
endmodule
